// ---- hw/ddsl_top.sv ----
// ddsl_top.sv: serial load, double buffering and registers of a dual dac
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "ddsl_map.svh"

module ddsl_top #(
  parameter int DATA_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // serial link pins
  input wire logic sync_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic load_outputs_n_i,
  // classic wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`DDSL_ADDR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // converter side
  output logic [DATA_W-1:0] dac_a_code_o,
  output logic [DATA_W-1:0] dac_b_code_o,
  output logic [1:0] refbuf_o,
  output logic [1:0] powerdown_mode_hi_o,
  output logic [1:0] powerdown_mode_lo_o,
  output logic input_buf_en_o
);

  // ======================================================
  // behaviour notes
  // every pin passes two flops, and frame select and serial clock then an edge flop,
  // so a pin edge acts about three clocks after it occurs
  // serial clock half periods must span three clocks or more
  // a word commits at its sixteenth falling serial edge
  // frame select rising after that only closes the frame
  // frame select rising before it drops the partial word
  // clocks after the sixteenth wait for a new frame fall
  // the load pin is a level: while low, pending codes move
  // a commit beside an active load stays pending one cycle
  // software load strobe counts as one low load cycle
  // pending clears only when a dac register is loaded
  // buffer and mode bits act at commit, not at load
  // link enable low leaves whole frames unseen
  // the bus answers every access after one wait state
  // ce_i low freezes pins, link, bus and registers alike
  // a reset needs no clock enable and clears every code

  // ======================================================
  // timing of one frame
  // frame select falls; three clocks later buffers wake
  // each falling serial edge shifts din in, msb first
  // the sixteenth edge writes the chosen input register
  // in the same clock the buffers go back to sleep
  // frame select then rises and the link waits in done
  // the load pin or strobe then copies pending codes

  // ======================================================
  // limitations
  // serial clocks faster than a sixth of clk_i are missed
  // din must settle a clock before each falling serial edge
  // frames that arrive while ce_i is low are lost whole
  // only byte lane 0 of a control write is honoured
  // unmapped offsets read zero and drop writes, still acked
  // reads of status show the count of the frame in flight
  // an aborted frame leaves its partial bits in the shifter
  // the strobe bit of control always reads back as zero
  // a load held low keeps copying each new commit
  // channels share one shifter, so words never overlap

  // ======================================================
  // register map
  // control: link enable, load strobe
  // status: buffers, pending b and a, load pin, bit count
  // channel a and b: input code, mode, buffer, dac code

  // ======================================================
  // helpers

  // narrow variants keep only their upper data bits
  function automatic logic [`DDSL_CODE_W-1:0] ddsl_code(
    input logic [`DDSL_WORD_W-1:0] word
  );
    logic [`DDSL_CODE_W-1:0] mask;
    mask = '1;
    mask = mask << (`DDSL_CODE_W - DATA_W);
    return word[`DDSL_CODE_MSB:0] & mask;
  endfunction

  // read view of one channel
  function automatic logic [31:0] ddsl_chan_word(
    input ddsl_pkg::ddsl_chan_t ch,
    input logic [`DDSL_CODE_W-1:0] dac
  );
    logic [31:0] w;
    w = '0;
    w[`DDSL_CODE_MSB:0] = ch.code;
    w[`DDSL_BIT_MODE_LO] = ch.powerdown_mode_lo;
    w[`DDSL_BIT_MODE_HI] = ch.powerdown_mode_hi;
    w[`DDSL_BIT_REFBUF] = ch.refbuf;
    w[`DDSL_CH_DAC_LSB +: `DDSL_CODE_W] = dac;
    return w;
  endfunction

  // one-cycle pulse on a high to low step of a synced pin
  function automatic logic ddsl_fell(
    input logic prev_lvl,
    input logic cur_lvl
  );
    return prev_lvl & ~cur_lvl;
  endfunction

  // read view of the control register
  function automatic logic [31:0] ddsl_ctrl_word(
    input logic link_en
  );
    logic [31:0] w;
    w = '0;
    w[`DDSL_CTRL_LINK_EN] = link_en;
    // the load strobe bit always reads back as zero
    return w;
  endfunction

  // read view of the status register
  function automatic logic [31:0] ddsl_status_word(
    input logic buf_en,
    input logic [1:0] pending,
    input logic load_lvl,
    input logic [3:0] bit_cnt
  );
    logic [31:0] w;
    w = '0;
    w[`DDSL_ST_BUF_EN] = buf_en;
    w[`DDSL_ST_PEND_LSB +: 2] = pending;
    w[`DDSL_ST_LOAD] = load_lvl;
    w[`DDSL_ST_CNT_LSB +: 4] = bit_cnt;
    return w;
  endfunction

  // input register contents carried by a complete word
  function automatic ddsl_pkg::ddsl_chan_t ddsl_chan_from_word(
    input logic [`DDSL_WORD_W-1:0] word
  );
    ddsl_pkg::ddsl_chan_t ch;
    ch.refbuf = word[`DDSL_BIT_REFBUF];
    ch.powerdown_mode_hi = word[`DDSL_BIT_MODE_HI];
    ch.powerdown_mode_lo = word[`DDSL_BIT_MODE_LO];
    ch.code = ddsl_code(word);
    return ch;
  endfunction

  // ======================================================
  // state
  // sync1, sync2: two synchroniser stages, one lane per pin
  // prev_sync_n, prev_sclk: last synced levels, for edges
  // link, bit_cnt, shift: serial sequencer and its word
  // buf_en: serial input buffers powered
  // in_reg, dac_code: the two banks of each channel
  // pending: input register newer than its dac register
  // link_en: software gate on the serial link
  // ack, rdata: bus answer and read data

  ddsl_pkg::ddsl_state_t state_reg;
  ddsl_pkg::ddsl_state_t state_next;

  // ======================================================
  // next state logic
  always_comb begin
    logic sync_fall;
    logic sclk_fall;
    logic sync_lvl;
    logic din_lvl;
    logic commit;
    logic [`DDSL_WORD_W-1:0] word;
    logic sw_load;
    logic load_req;
    logic bus_req;
    logic bus_wr;
    sync_fall = 1'b0;
    sclk_fall = 1'b0;
    sync_lvl = 1'b1;
    din_lvl = 1'b0;
    commit = 1'b0;
    word = '0;
    sw_load = 1'b0;
    load_req = 1'b0;
    bus_req = 1'b0;
    bus_wr = 1'b0;
    // hold everything unless a branch below moves it
    state_next = state_reg;

    // two flip-flop synchronisers for every pin
    state_next.sync1 = {load_outputs_n_i, din_i, sclk_i, sync_n_i};
    state_next.sync2 = state_reg.sync1;
    state_next.prev_sync_n = state_reg.sync2[`DDSL_PIN_SYNC];
    state_next.prev_sclk = state_reg.sync2[`DDSL_PIN_SCLK];

    // edges seen on the synchronised pins
    sync_lvl = state_reg.sync2[`DDSL_PIN_SYNC];
    din_lvl = state_reg.sync2[`DDSL_PIN_DIN];
    sync_fall = ddsl_fell(state_reg.prev_sync_n, sync_lvl);
    sclk_fall = ddsl_fell(state_reg.prev_sclk,
                          state_reg.sync2[`DDSL_PIN_SCLK]);
    word = {state_reg.shift[`DDSL_WORD_W-2:0], din_lvl};

    // link sequencer
    case (state_reg.link)
      ddsl_pkg::DDSL_IDLE, ddsl_pkg::DDSL_DONE: begin
        if (sync_fall && state_reg.link_en) begin
          state_next.link = ddsl_pkg::DDSL_SHIFT;
          state_next.bit_cnt = '0;
          state_next.buf_en = 1'b1;
        end
      end
      ddsl_pkg::DDSL_SHIFT: begin
        if (sync_lvl) begin
          state_next.link = ddsl_pkg::DDSL_IDLE;
          state_next.buf_en = 1'b0;
        end else if (sclk_fall) begin
          state_next.shift = word;
          state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
          if (state_reg.bit_cnt == `DDSL_LAST_BIT) begin
            commit = 1'b1;
            state_next.link = ddsl_pkg::DDSL_DONE;
            state_next.buf_en = 1'b0;
          end
        end
      end
      default: begin
        // unused encoding falls back to idle
        state_next.link = ddsl_pkg::DDSL_IDLE;
        state_next.buf_en = 1'b0;
      end
    endcase

    // wishbone slave: one wait state, ack for one cycle
    bus_req = cyc_i & stb_i;
    // writes act at the ack edge, while the master still holds
    bus_wr = bus_req & we_i & state_reg.ack;
    state_next.ack = bus_req & ~state_reg.ack;
    // read data is latched at the request edge and then held
    if (bus_req && !state_reg.ack) begin
      case (adr_i)
        `DDSL_REG_CTRL: begin
          state_next.rdata = ddsl_ctrl_word(state_reg.link_en);
        end
        `DDSL_REG_STATUS: begin
          state_next.rdata = ddsl_status_word(state_reg.buf_en,
            state_reg.pending, state_reg.sync2[`DDSL_PIN_LOAD],
            state_reg.bit_cnt);
        end
        `DDSL_REG_CHAN_A: begin
          state_next.rdata = ddsl_chan_word(state_reg.in_reg[0],
                                            state_reg.dac_code[0]);
        end
        `DDSL_REG_CHAN_B: begin
          state_next.rdata = ddsl_chan_word(state_reg.in_reg[1],
                                            state_reg.dac_code[1]);
        end
        default: begin
          state_next.rdata = '0;
        end
      endcase
    end

    // control register write, byte lane 0 only
    if (bus_wr && adr_i == `DDSL_REG_CTRL && sel_i[0]) begin
      state_next.link_en = dat_i[`DDSL_CTRL_LINK_EN];
      sw_load = dat_i[`DDSL_CTRL_SW_LOAD];
    end

    // the software strobe acts as one cycle of the pin low
    // load low is transparent
    load_req = ~state_reg.sync2[`DDSL_PIN_LOAD] | sw_load;

    // double buffering per channel
    // copy first, so a commit below may set pending again
    for (int i = 0; i < 2; i++) begin
      if (load_req && state_reg.pending[i]) begin
        state_next.dac_code[i] = state_reg.in_reg[i].code;
        state_next.pending[i] = 1'b0;
      end
      if (commit && word[`DDSL_BIT_CHAN] == 1'(i)) begin
        state_next.in_reg[i] = ddsl_chan_from_word(word);
        // set wins over a same-cycle load clear
        state_next.pending[i] = 1'b1;
      end
    end
  end

  // ======================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      // sync stages reset to the idle high level: no false edge
      state_reg.sync1 <= `DDSL_PIN_IDLE;
      state_reg.sync2 <= `DDSL_PIN_IDLE;
      state_reg.prev_sync_n <= 1'b1;
      state_reg.prev_sclk <= 1'b1;
      state_reg.link <= ddsl_pkg::DDSL_IDLE;
      state_reg.link_en <= `DDSL_CTRL_RESET;
    end else if (ce_i) begin
      // ce_i low holds every flop, the pin stages too
      state_reg <= state_next;
    end
  end

  // ======================================================
  // outputs, all straight from flip-flops

  // narrow variants keep the upper bits of each code
  // codes passed as straight binary
  assign dac_a_code_o = state_reg.dac_code[0][`DDSL_CODE_MSB -: DATA_W];
  assign dac_b_code_o = state_reg.dac_code[1][`DDSL_CODE_MSB -: DATA_W];

  // mode pins decoded by analog side
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      refbuf_o[i] = state_reg.in_reg[i].refbuf;
      powerdown_mode_hi_o[i] = state_reg.in_reg[i].powerdown_mode_hi;
      powerdown_mode_lo_o[i] = state_reg.in_reg[i].powerdown_mode_lo;
    end
  end

  // buffer flag, bus answer and read data from their flops
  assign input_buf_en_o = state_reg.buf_en;
  assign ack_o = state_reg.ack;
  assign dat_o = state_reg.rdata;

endmodule // ddsl_top

// ---- include/ddsl_map.svh ----
// ddsl_map.svh: constants of the dual dac serial load block
`ifndef DDSL_MAP_SVH
`define DDSL_MAP_SVH

// ======================================================
// serial word layout
`define DDSL_WORD_W 16
`define DDSL_LAST_BIT 4'h0f
`define DDSL_BIT_CHAN 15
`define DDSL_BIT_REFBUF 14
`define DDSL_BIT_MODE_HI 13
`define DDSL_BIT_MODE_LO 12
`define DDSL_CODE_W 12
`define DDSL_CODE_MSB 11

// ======================================================
// synchroniser lanes and their idle level
`define DDSL_PIN_SYNC 0
`define DDSL_PIN_SCLK 1
`define DDSL_PIN_DIN 2
`define DDSL_PIN_LOAD 3
`define DDSL_PIN_IDLE 4'hf

// ======================================================
// wishbone register map (byte addresses)
`define DDSL_ADDR_W 4
`define DDSL_REG_CTRL 4'h0
`define DDSL_REG_STATUS 4'h4
`define DDSL_REG_CHAN_A 4'h8
`define DDSL_REG_CHAN_B 4'hc
`define DDSL_CTRL_LINK_EN 0
`define DDSL_CTRL_SW_LOAD 1
`define DDSL_CTRL_RESET 1'b1
`define DDSL_CH_DAC_LSB 16
`define DDSL_ST_CNT_LSB 4
`define DDSL_ST_BUF_EN 0
`define DDSL_ST_PEND_LSB 1
`define DDSL_ST_LOAD 3

`endif

// ---- include/ddsl_pkg.sv ----
// ddsl_pkg.sv: types of the dual dac serial load block
`include "ddsl_map.svh"

package ddsl_pkg;

  // link sequencer states
  typedef enum logic [1:0] {
    DDSL_IDLE,
    DDSL_SHIFT,
    DDSL_DONE
  } ddsl_link_t;

  // one channel's input register with its control bits
  typedef struct packed {
    logic refbuf;
    logic powerdown_mode_hi;
    logic powerdown_mode_lo;
    logic [`DDSL_CODE_W-1:0] code;
  } ddsl_chan_t;

  // whole state of the block
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic prev_sync_n;
    logic prev_sclk;
    ddsl_link_t link;
    logic [3:0] bit_cnt;
    logic [`DDSL_WORD_W-1:0] shift;
    logic buf_en;
    ddsl_chan_t [1:0] in_reg;
    logic [1:0][`DDSL_CODE_W-1:0] dac_code;
    logic [1:0] pending;
    logic link_en;
    logic ack;
    logic [31:0] rdata;
  } ddsl_state_t;

endpackage

// ---- verif/ddsl_host.sv ----
// ddsl_host.sv: host serial port model driving the three-wire link
`timescale 1ns/1ps
module ddsl_host (
  output logic sync_n_o,
  output logic sclk_o,
  output logic din_o
);
  // idle pins: frame off, clock parked high
  initial begin
    sync_n_o = 1'b1;
    sclk_o = 1'b1;
    din_o = 1'b1;
  end
  // ====================================================
  // one frame of n clocks, off the system clock edges
  task automatic send(input logic [15:0] w, input int n);
    #3 sync_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      din_o = w[15 - (i % 16)];
      #40 sclk_o = 1'b0;
      #40 sclk_o = 1'b1;
    end
    #40 sync_n_o = 1'b1;
    din_o = ~din_o; // no stale bit once released
    #160;
  endtask
endmodule // ddsl_host

// ---- verif/ddsl_props.sv ----
// ddsl_props.sv: concurrent checks on the ports of ddsl_top
`timescale 1ns/1ps
module ddsl_props #(
  parameter int DATA_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic sync_n_i,
  input wire logic load_outputs_n_i,
  input wire logic ack_o,
  input wire logic [DATA_W-1:0] dac_a_code_o,
  input wire logic [DATA_W-1:0] dac_b_code_o,
  input wire logic [1:0] refbuf_o,
  input wire logic [1:0] powerdown_mode_hi_o,
  input wire logic [1:0] powerdown_mode_lo_o,
  input wire logic input_buf_en_o
);
  logic [3:0] quiet_cnt;
  // cycles since load pin low or bus busy
  always_ff @(posedge clk_i) begin
    if (rst_i || !load_outputs_n_i || cyc_i)
      quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hf)
      quiet_cnt <= quiet_cnt + 4'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ====================================================
  // assertions
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  AST_ACK_WAIT: assert property ($rose(cyc_i && stb_i) |=> ack_o)
    else $error("ack late");
  AST_ACK_CAUSE: assert property (ack_o |-> cyc_i && stb_i)
    else $error("ack without request");
  AST_RST_CLEAR: assert property ($fell(rst_i) |->
    !{dac_a_code_o, dac_b_code_o, refbuf_o, powerdown_mode_hi_o,
    powerdown_mode_lo_o, input_buf_en_o})
    else $error("outputs not cleared");
  AST_LOAD_HOLD: assert property (
    (load_outputs_n_i && !cyc_i)[*6] |=>
    $stable({dac_a_code_o, dac_b_code_o}))
    else $error("dac moved while load high");
  AST_DAC_CAUSE: assert property (
    !$stable({dac_a_code_o, dac_b_code_o}) |-> quiet_cnt < 4'h6)
    else $error("dac moved without load");
  AST_CTL_COMMIT: assert property (
    $changed({refbuf_o, powerdown_mode_hi_o, powerdown_mode_lo_o})
    |-> !input_buf_en_o && !sync_n_i)
    else $error("control bits moved outside commit");
  AST_BUF_ON: assert property ($rose(input_buf_en_o) |-> !sync_n_i)
    else $error("buffers woke without frame");
  cover property ($rose(ack_o));
  cover property ($fell(input_buf_en_o));
  cover property ($changed(dac_b_code_o));
endmodule // ddsl_props

bind ddsl_top ddsl_props #(.DATA_W(DATA_W)) u_props (.clk_i, .rst_i,
  .cyc_i, .stb_i, .sync_n_i, .load_outputs_n_i, .ack_o, .dac_a_code_o,
  .dac_b_code_o, .refbuf_o, .powerdown_mode_hi_o, .powerdown_mode_lo_o,
  .input_buf_en_o);

// ---- verif/ddsl_top_bench.sv ----
// ddsl_top_bench.sv: self-checking bench of the dual dac serial load
`timescale 1ns/1ps
module ddsl_top_bench;
  logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, input_buf_en_o;
  logic sync_n_i, sclk_i, din_i, load_outputs_n_i;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, r;
  logic [11:0] dac_a_code_o, dac_b_code_o;
  logic [1:0] refbuf_o, powerdown_mode_hi_o, powerdown_mode_lo_o;
  int num_errors, checks, seed;
  int code[2], dac[2], ctl[2], pend[2];
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ddsl_top dut (.clk_i, .rst_i, .ce_i, .sync_n_i, .sclk_i, .din_i,
    .load_outputs_n_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .dac_a_code_o, .dac_b_code_o, .refbuf_o,
    .powerdown_mode_hi_o, .powerdown_mode_lo_o, .input_buf_en_o);
  ddsl_host host (.sync_n_o(sync_n_i), .sclk_o(sclk_i), .din_o(din_i));
  // ====================================================
  // compare, bus and model tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task outs();
    repeat (8) @(posedge clk_i);
    chk({dac_b_code_o, dac_a_code_o}, {dac[1][11:0], dac[0][11:0]});
    chk({refbuf_o, powerdown_mode_hi_o, powerdown_mode_lo_o}, {ctl[1][2],
      ctl[0][2], ctl[1][1], ctl[0][1], ctl[1][0], ctl[0][0]});
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk(r[3:0], {1'b1, pend[1][0], pend[0][0], 1'b0});
    for (int c = 0; c < 2; c++) begin
      wb(1'b0, 4'(8 + 4 * c), 32'h0000_0000);
      chk(r & 32'h0fff_7fff, {4'h0, dac[c][11:0], 1'b0, ctl[c][2:0],
        code[c][11:0]});
    end
  endtask
  task frame(input logic [15:0] w, input int n);
    host.send(w, n);
    if (n >= 16) begin
      code[w[15]] = w[11:0];
      ctl[w[15]] = w[14:12];
      pend[w[15]] = 1;
    end
    outs();
  endtask
  task ld(input logic sw);
    if (sw) wb(1'b1, 4'h0, 32'h0000_0003);
    else begin
      load_outputs_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      load_outputs_n_i <= 1'b1;
    end
    for (int c = 0; c < 2; c++) if (pend[c] != 0) begin
      dac[c] = code[c];
      pend[c] = 0;
    end
    outs();
  endtask
  task close_out();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ====================================================
  // main sequence
  initial begin
    {rst_i, load_outputs_n_i, ce_i} = 3'h7;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    seed = $urandom(32'h8876_62d4);
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    outs();
    wb(1'b0, 4'h0, 32'h0000_0000);
    chk(r, 32'h0000_0001);
    wb(1'b0, 4'h2, 32'h0000_0000);
    chk(r, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
      frame({i[0], i[1], i[2:1], 12'($urandom)}, 16);
    ld(1'b0);
    ld(1'b0);
    $display("test modes done");
    frame(16'($urandom), 16);
    ld(1'b1);
    frame(16'($urandom), 9);
    frame(16'($urandom), 20);
    $display("test frames done");
    ce_i <= 1'b0;
    host.send(16'($urandom), 16);
    @(posedge clk_i);
    ce_i <= 1'b1;
    outs();
    $display("test enable done");
    wb(1'b1, 4'h0, 32'h0000_0000);
    host.send(16'($urandom), 16);
    outs();
    wb(1'b1, 4'h0, 32'h0000_0001);
    $display("test link done");
    close_out();
  end
  // watchdog against a hang
  initial begin
    #200_000;
    num_errors++;
    close_out();
  end
endmodule // ddsl_top_bench
